// ==== logic/csdb_exec.sv ====
// Executor for unsigned compare-skip, decimal adjust and decrement ops.
// Assumes the fetch stage holds an opcode until taken and the banked
// file memory returns read data one clock after the read strobe.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - skip when file value greater than working
// - decode compare-greater by 0110 010a pattern
// - skip when file value less than working
// - decode compare-less by 0110 000a pattern
// - decimal adjust adds 6 to each digit above 9 or carried
// - decimal adjust opcode is 0x0007
// - decrement file, destination bit picks target
// - decode decrement by 0000 01da pattern
// - decrement, skip on zero, flags kept
// - decrement, skip on non-zero result
// - decode skip-nonzero by 0100 11da pattern
// - bank bit picks access bank or select
module csdb_exec (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fetch stage
    input wire logic instr_valid,
    input wire logic [15:0] instr_opcode,
    input wire logic next_two_word,
    output logic instr_ready,
    output logic skip_nop,
    output logic illegal_op,
    // Core registers
    input wire logic [7:0] working_register,
    input wire logic [3:0] bank_select_register,
    input wire csdb_pkg::csdb_flags_t status_in,
    output logic w_wr_en,
    output logic [7:0] w_wr_data,
    output logic status_wr_en,
    output csdb_pkg::csdb_flags_t status_wr_data,
    // Banked file memory
    input wire logic [7:0] file_rd_data,
    output logic file_rd_en,
    output logic [11:0] file_addr,
    output logic file_wr_en,
    output logic [7:0] file_wr_data
);
    import csdb_pkg::*;

    csdb_state_t q;
    csdb_state_t nxt_q;
    csdb_op_t dec_op;
    logic taken;
    logic [7:0] fval;
    logic [7:0] dec_res;
    logic [8:0] bcd_lo;
    logic [8:0] bcd_hi;
    logic do_skip;

    assign taken = instr_valid && instr_ready;
    assign fval = file_rd_data;
    assign dec_res = fval - 8'h01;

    // Opcode decode; the low byte is the file address except for the decimal adjust
    always_comb begin
        dec_op = OP_NONE;
        if (instr_opcode[15:9] == OPC_CSG) begin
            dec_op = OP_CSG;
        end else if (instr_opcode[15:9] == OPC_CSL) begin
            dec_op = OP_CSL;
        end else if (instr_opcode == OPC_DAW) begin
            dec_op = OP_DAW;
        end else if (instr_opcode[15:10] == OPC_DEC) begin
            dec_op = OP_DEC;
        end else if (instr_opcode[15:10] == OPC_DSZ) begin
            dec_op = OP_DSZ;
        end else if (instr_opcode[15:10] == OPC_DSN) begin
            dec_op = OP_DSN;
        end
    end

    // Decimal adjust; the low correction may carry into the high digit
    always_comb begin
        bcd_lo = {1'b0, working_register};
        if (working_register[3:0] > BCD_MAX || status_in.dc) begin
            bcd_lo = bcd_lo + BCD_LO_ADJ;
        end
        bcd_hi = bcd_lo;
        if (bcd_lo[7:4] > BCD_MAX || status_in.c || bcd_lo[8]) begin
            bcd_hi = {1'b0, bcd_lo[7:0]} + BCD_HI_ADJ;
        end
    end

    // Skip decision, valid in the execute state only
    always_comb begin
        case (q.op)
            OP_CSG: do_skip = fval > working_register;
            OP_CSL: do_skip = fval < working_register;
            OP_DSZ: do_skip = dec_res == DATA_RST;
            OP_DSN: do_skip = dec_res != DATA_RST;
            default: do_skip = 1'b0;
        endcase
    end

    // Next state; write strobes and nops are one-cycle pulses
    always_comb begin
        nxt_q = q;
        nxt_q.rd_en = 1'b0;
        nxt_q.wr_file = 1'b0;
        nxt_q.wr_w = 1'b0;
        nxt_q.wr_stat = 1'b0;
        nxt_q.skip_nop = 1'b0;
        nxt_q.illegal = 1'b0;
        case (q.st)
            ST_IDLE: begin
                if (taken) begin
                    nxt_q.op = dec_op;
                    nxt_q.dest = instr_opcode[DEST_BIT];
                    // access bank or bank select register
                    if (instr_opcode[BANK_BIT]) begin
                        nxt_q.addr = {bank_select_register,
                            instr_opcode[7:0]};
                    end else if (instr_opcode[7:0] < ACC_SPLIT) begin
                        nxt_q.addr = {ACC_LO_BANK, instr_opcode[7:0]};
                    end else begin
                        nxt_q.addr = {ACC_HI_BANK, instr_opcode[7:0]};
                    end
                    if (dec_op == OP_NONE) begin
                        nxt_q.illegal = 1'b1;
                    end else if (dec_op == OP_DAW) begin
                        // adjusted value written back to W
                        nxt_q.res = bcd_hi[7:0];
                        nxt_q.stat = status_in;
                        // Low correction may carry out of the byte too
                        nxt_q.stat.c = status_in.c | bcd_lo[8] | bcd_hi[8];
                        nxt_q.wr_w = 1'b1;
                        nxt_q.wr_stat = 1'b1;
                    end else begin
                        nxt_q.rd_en = 1'b1;
                        nxt_q.st = ST_READ;
                    end
                end
            end
            ST_READ: begin
                nxt_q.st = ST_EXEC;
            end
            ST_EXEC: begin
                nxt_q.res = dec_res;
                if (q.op == OP_DEC || q.op == OP_DSZ || q.op == OP_DSN) begin
                    // destination bit picks file or W
                    nxt_q.wr_file = q.dest;
                    nxt_q.wr_w = !q.dest;
                end
                // only the plain decrement touches flags
                if (q.op == OP_DEC) begin
                    nxt_q.wr_stat = 1'b1;
                    nxt_q.stat.c = fval != DATA_RST;
                    nxt_q.stat.dc = fval[3:0] != 4'h0;
                    nxt_q.stat.z = dec_res == DATA_RST;
                    nxt_q.stat.n = dec_res[7];
                    nxt_q.stat.ov = fval == 8'h80;
                end
                // discard next word, one or two nops
                if (do_skip) begin
                    nxt_q.st = ST_SKIP;
                    nxt_q.skip_nop = 1'b1;
                    nxt_q.nop_left = next_two_word ? SKIP_TWO : SKIP_ONE;
                end else begin
                    nxt_q.st = ST_IDLE;
                end
            end
            ST_SKIP: begin
                nxt_q.nop_left = q.nop_left - 2'h1;
                if (q.nop_left == SKIP_TWO) begin
                    nxt_q.skip_nop = 1'b1;
                end else begin
                    nxt_q.st = ST_IDLE;
                end
            end
            default: begin
                nxt_q.st = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '{st: ST_IDLE, op: OP_NONE, dest: 1'b0, addr: ADDR_RST,
                rd_en: 1'b0, wr_file: 1'b0, wr_w: 1'b0, wr_stat: 1'b0,
                res: DATA_RST, stat: '0, skip_nop: 1'b0,
                nop_left: 2'h0, illegal: 1'b0};
        end else begin
            q <= nxt_q;
        end
    end

    // Outputs; ready is the only combinational one
    assign instr_ready = q.st == ST_IDLE && !q.skip_nop;
    assign skip_nop = q.skip_nop;
    assign illegal_op = q.illegal;
    assign w_wr_en = q.wr_w;
    assign w_wr_data = q.res;
    assign status_wr_en = q.wr_stat;
    assign status_wr_data = q.stat;
    assign file_rd_en = q.rd_en;
    assign file_addr = q.addr;
    assign file_wr_en = q.wr_file;
    assign file_wr_data = q.res;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_exec(csdb_op_t o);
        q.st == ST_EXEC && q.op == o;
    endsequence

    a_greater_skip: assert property (
        s_exec(OP_CSG) ##0 (fval > working_register) |=> skip_nop)
        else $error("greater compare did not skip");
    a_less_skip: assert property (
        s_exec(OP_CSL) ##0 (fval >= working_register) |=> !skip_nop)
        else $error("less compare skipped wrongly");
    a_greater_decode: assert property (
        taken && instr_opcode[15:9] == OPC_CSG |=> q.op == OP_CSG ##2
        q.st != ST_READ)
        else $error("greater opcode misdecoded");
    a_adjust_write: assert property (
        taken && instr_opcode == OPC_DAW |=> w_wr_en && instr_ready)
        else $error("adjust did not write W at once");
    a_dec_file: assert property (
        s_exec(OP_DEC) ##0 q.dest |=> file_wr_en && !w_wr_en &&
        file_wr_data == $past(fval) - 8'h01)
        else $error("decrement result wrong");
    a_zero_keeps: assert property (
        s_exec(OP_DSZ) |=> !status_wr_en && (skip_nop ==
        ($past(fval) == 8'h01)))
        else $error("skip-zero flags or skip wrong");
    a_nonzero_skip: assert property (
        s_exec(OP_DSN) ##0 (fval != 8'h01) |=> skip_nop)
        else $error("skip-nonzero did not skip");
    a_access_bank: assert property (
        taken && !instr_opcode[BANK_BIT] && instr_opcode[7] |=>
        file_addr[11:8] == ACC_HI_BANK)
        else $error("access bank address wrong");
    a_skip_two: assert property (
        q.st == ST_EXEC && do_skip && next_two_word |=>
        skip_nop [*2] ##1 (!skip_nop && instr_ready))
        else $error("two-word skip length wrong");
    a_cmp_flags: assert property (
        q.st == ST_EXEC && (q.op == OP_CSG || q.op == OP_CSL) |=>
        !status_wr_en && !w_wr_en)
        else $error("compare wrote registers");
endmodule

`default_nettype wire

// ==== logic/csdb_pkg.sv ====
// Package for the compare, skip, decrement and decimal adjust executor.
// Assumes one core clock; the file memory answers a read one cycle later.
package csdb_pkg;
    // Opcode patterns, upper bits compared against the fetched word
    localparam logic [6:0] OPC_CSG = 7'h32;      // 0110 010
    localparam logic [6:0] OPC_CSL = 7'h30;      // 0110 000
    localparam logic [5:0] OPC_DEC = 6'h01;      // 0000 01
    localparam logic [5:0] OPC_DSZ = 6'h0b;      // 0010 11
    localparam logic [5:0] OPC_DSN = 6'h13;      // 0100 11
    localparam logic [15:0] OPC_DAW = 16'h0007;
    // Opcode field positions
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;
    // Access bank: low half maps to bank 0, high half to the top bank
    localparam logic [7:0] ACC_SPLIT = 8'h80;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;
    // BCD correction constants
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [8:0] BCD_LO_ADJ = 9'h006;
    localparam logic [8:0] BCD_HI_ADJ = 9'h060;
    // Extra no-operation cycles for a taken skip
    localparam logic [1:0] SKIP_ONE = 2'h1;
    localparam logic [1:0] SKIP_TWO = 2'h2;
    // Reset values
    localparam logic [11:0] ADDR_RST = 12'h000;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        OP_NONE, OP_CSG, OP_CSL, OP_DAW, OP_DEC, OP_DSZ, OP_DSN
    } csdb_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_SKIP} csdb_st_t;

    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } csdb_flags_t;

    typedef struct packed {
        csdb_st_t st;
        csdb_op_t op;
        logic dest;
        logic [11:0] addr;
        logic rd_en;
        logic wr_file;
        logic wr_w;
        logic wr_stat;
        logic [7:0] res;
        csdb_flags_t stat;
        logic skip_nop;
        logic [1:0] nop_left;
        logic illegal;
    } csdb_state_t;
endpackage

// ==== tb/compare_skip_decrement_bcd_exec_tb.sv ====
// Self-checking bench for the compare, skip, decrement and BCD executor.
// Assumes the package constants and the memory partner model.
`timescale 1ns/1ps
`default_nettype none
module compare_skip_decrement_bcd_exec_tb;
    import csdb_pkg::*;
    logic clk = 0, reset = 1, instr_valid = 0, next_two_word = 0;
    logic [15:0] instr_opcode = 16'h0000;
    logic [7:0] working_register = 8'h00;
    logic [3:0] bank_select_register = 4'h0;
    csdb_flags_t status_in = '0;
    logic instr_ready, skip_nop, illegal_op, w_wr_en, status_wr_en;
    logic file_rd_en, file_wr_en, cw, cf, cs, il;
    logic [7:0] w_wr_data, file_wr_data, file_rd_data, wv, fv;
    logic [11:0] file_addr, fa;
    logic [2:0] nn;
    logic [4:0] sv;
    csdb_flags_t status_wr_data;
    int error_cnt = 0;
    int n_tests = 0;
    csdb_exec DUT (.clk(clk), .reset(reset), .instr_valid(instr_valid),
        .instr_opcode(instr_opcode), .next_two_word(next_two_word),
        .instr_ready(instr_ready), .skip_nop(skip_nop),
        .illegal_op(illegal_op), .working_register(working_register),
        .bank_select_register(bank_select_register),
        .status_in(status_in), .w_wr_en(w_wr_en), .w_wr_data(w_wr_data),
        .status_wr_en(status_wr_en), .status_wr_data(status_wr_data),
        .file_rd_data(file_rd_data), .file_rd_en(file_rd_en),
        .file_addr(file_addr), .file_wr_en(file_wr_en),
        .file_wr_data(file_wr_data));
    csdb_mem_model mem (.clk(clk), .file_rd_en(file_rd_en),
        .file_addr(file_addr), .file_wr_en(file_wr_en),
        .file_wr_data(file_wr_data), .file_rd_data(file_rd_data));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                       input string m);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // Expected physical address; access bank splits at 0x80
    function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
        if (a)
            return {bank_select_register, f};
        return {f >= ACC_SPLIT ? ACC_HI_BANK : ACC_LO_BANK, f};
    endfunction
    // Issue one opcode and collect every strobe until ready returns
    task automatic run(input logic [15:0] op, input logic two);
        int k;
        k = 0;
        // Let an edge pass so valid is never dropped and raised at once
        @(negedge clk);
        while (instr_ready !== 1'b1) @(negedge clk);
        instr_opcode = op;
        next_two_word = two;
        instr_valid = 1;
        @(negedge clk);
        instr_valid = 0;
        {cw, cf, cs, il, nn} = '0;
        {wv, fv, sv} = 'x;
        forever begin
            cw |= w_wr_en === 1'b1;
            cf |= file_wr_en === 1'b1;
            cs |= status_wr_en === 1'b1;
            il |= illegal_op === 1'b1;
            if (w_wr_en === 1'b1) wv = w_wr_data;
            if (file_wr_en === 1'b1) fv = file_wr_data;
            if (status_wr_en === 1'b1) sv = status_wr_data;
            if (file_rd_en === 1'b1) fa = file_addr;
            if (skip_nop === 1'b1) nn++;
            if (instr_ready === 1'b1 || k > 8) break;
            k++;
            @(negedge clk);
        end
    endtask
    task automatic t_cmp();
        logic [7:0] v [3] = '{8'h80, 8'h7f, 8'h10};
        logic [11:0] a;
        working_register = 8'h7f;
        bank_select_register = 4'h5;
        for (int i = 0; i < 6; i++) begin
            a = ea(i[1], 8'h90);
            mem.ram[a] = v[i % 3];
            run({i < 3 ? OPC_CSG : OPC_CSL, i[1], 8'h90}, i[0]);
            chk(fa, a, "compare address");
            chk(nn, i == 0 ? 1 : i == 5 ? 2 : 0, "compare skip");
            chk({cw, cf, cs}, 3'h0, "compare writes");
        end
        $display("compare test done");
    endtask
    task automatic t_daw();
        logic [7:0] wi [5] = '{8'ha5, 8'hce, 8'h42, 8'h19, 8'h12};
        logic [7:0] wo [5] = '{8'h05, 8'h34, 8'h42, 8'h1f, 8'h72};
        logic [1:0] ci [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1};
        logic [4:0] co = 5'h13;
        for (int i = 0; i < 5; i++) begin
            working_register = wi[i];
            status_in = {3'h5, ci[i]};
            run(OPC_DAW, 1'b0);
            chk(wv, wo[i], "bcd value");
            chk(sv, {3'h5, ci[i][1], co[i]}, "bcd flags");
            chk(cf, 1'b0, "bcd file write");
        end
        $display("bcd test done");
    endtask
    task automatic t_dec();
        logic [7:0] fi [3] = '{8'h01, 8'h80, 8'h00};
        logic [7:0] fl [3] = '{8'h10, 8'h22, 8'ha0};
        logic [4:0] ef [3] = '{5'h07, 5'h09, 5'h10};
        logic [11:0] a;
        bank_select_register = 4'h3;
        for (int i = 0; i < 3; i++) begin
            a = ea(i == 1, fl[i]);
            mem.ram[a] = fi[i];
            run({OPC_DEC, i == 1, i == 1, fl[i]}, 1'b0);
            chk(fa, a, "dec address");
            chk(i == 1 ? fv : wv, 8'(fi[i] - 8'h01), "dec result");
            chk({cw, cf}, i == 1 ? 2'h1 : 2'h2, "dec target");
            chk(sv, ef[i], "dec flags");
        end
        $display("decrement test done");
    endtask
    task automatic t_dsk();
        logic [5:0] op [4] = '{OPC_DSZ, OPC_DSZ, OPC_DSN, OPC_DSN};
        logic [7:0] fi [4] = '{8'h01, 8'h05, 8'h01, 8'h05};
        logic [2:0] en [4] = '{3'h2, 3'h0, 3'h0, 3'h1};
        for (int i = 0; i < 4; i++) begin
            mem.ram[12'h030 + i] = fi[i];
            run({op[i], ~i[0], 1'b0, 8'h30 + 8'(i)}, i == 0);
            chk(i[0] ? wv : fv, 8'(fi[i] - 8'h01), "skip result");
            chk(nn, en[i], "skip count");
            chk(cs, 1'b0, "skip flags");
        end
        run(16'h0004, 1'b0);
        chk({il, cw, cf, cs}, 4'h8, "foreign opcode");
        $display("skip test done");
    endtask
    initial begin
        #150000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (3) @(negedge clk);
        reset = 0;
        @(negedge clk);
        t_cmp();
        t_daw();
        t_dec();
        t_dsk();
        complete_run();
    end
endmodule
`default_nettype wire

// ==== tb/csdb_mem_model.sv ====
// Banked file memory partner for the executor.
// Assumes strobes and address come from the executor on clk.
`timescale 1ns/1ps
`default_nettype none
module csdb_mem_model (
    // Clock
    input wire logic clk,
    // Executor side
    input wire logic file_rd_en,
    input wire logic [11:0] file_addr,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wr_data,
    output logic [7:0] file_rd_data
);
    logic [7:0] ram [4096];
    logic [7:0] last_ff = 8'h00;
    logic vld_ff = 1'b0;
    // Read answers one clock later; testbench preloads ram directly
    always @(posedge clk) begin
        vld_ff <= file_rd_en;
        if (file_rd_en) last_ff <= ram[file_addr];
        if (file_wr_en) ram[file_addr] <= file_wr_data;
    end
    // Stale data is inverted so a late sample cannot pass by luck
    assign file_rd_data = vld_ff ? last_ff : ~last_ff;
endmodule
`default_nettype wire
